// file: umfc_defines.vh
`ifndef UMFC_DEFINES_VH
`define UMFC_DEFINES_VH

// ==========================================================
// register byte addresses on the bus
`define UMFC_A_FIFO_CTRL 8'h00
`define UMFC_A_LINE_CTRL 8'h04
`define UMFC_A_ENH_FEAT 8'h08
`define UMFC_A_ADD_CTRL 8'h0C
`define UMFC_A_MODE_CTRL 8'h10
`define UMFC_A_INDEX 8'h14
`define UMFC_A_INDEX_DATA 8'h18
`define UMFC_A_ADD_STATUS 8'h1C
`define UMFC_A_RX_FILL 8'h20
`define UMFC_A_TX_FILL 8'h24
`define UMFC_A_MODE_STATUS 8'h28

// ==========================================================
// indexed control set entries
`define UMFC_IX_PRESCALE 8'h01
`define UMFC_IX_EXT_CLK 8'h02
`define UMFC_IX_OVERSAMPLE 8'h03
`define UMFC_IX_RX_TRIG 8'h04
`define UMFC_IX_TX_TRIG 8'h05
`define UMFC_IX_FLOW_LO 8'h06
`define UMFC_IX_FLOW_HI 8'h07

// ==========================================================
// field positions
`define UMFC_B_FIFO_EN 0
`define UMFC_B_RX_FLUSH 1
`define UMFC_B_TX_FLUSH 2
`define UMFC_B_FIFO_SIZE 5
`define UMFC_B_DLAB 7
`define UMFC_B_ENHANCED 4
`define UMFC_B_RX_DISABLE 0
`define UMFC_B_TX_DISABLE 1
`define UMFC_B_ARB_TRIG 5
`define UMFC_B_PRESC_EN 0
`define UMFC_B_CK_RX_EXT 0
`define UMFC_B_CK_RX_1X 1
`define UMFC_B_CK_TX_EXT 4
`define UMFC_B_CK_TX_1X 5
`define UMFC_B_CK_DTR_OUT 7

// ==========================================================
// reset values
`define UMFC_RST_PRESCALE 8'h20
`define UMFC_RST_OVERSAMPLE 8'h00
`define UMFC_RST_ZERO 8'h00
`define UMFC_RST_RX_TRIG 8'h01
`define UMFC_RST_FLOW_HI 8'h01

// ==========================================================
// depths, sample counts and prescaler figures
`define UMFC_DEPTH_BYTE 8'h01
`define UMFC_DEPTH_SMALL 8'h10
`define UMFC_DEPTH_LARGE 8'h80
`define UMFC_OSR_DEFAULT 5'h10
`define UMFC_OSR_MIN 4'h4
`define UMFC_OSR_ONE 5'h01
`define UMFC_PRESC_ONE 8'h08
`define UMFC_PRESC_STEP 9'h008

`endif

// file: umfc_prescaler.v
`timescale 1ns/1ns
`include "umfc_defines.vh"

// ==========================================================
// fractional clock divider, divisor in eighths of a cycle
module umfc_prescaler (
    input wire hclk,
    input wire hresetn,
    input wire enable,
    input wire [7:0] divisor,
    output reg tick_q
);

    reg [8:0] acc_q;
    reg [8:0] acc_d;
    reg tick_d;
    wire [8:0] div_w;

    // a zero integer part is taken as divide by one
    assign div_w = (divisor < `UMFC_PRESC_ONE) ? {1'b0, `UMFC_PRESC_ONE} : {1'b0, divisor};

    // add one whole cycle per clock, tick whenever the divisor is reached
    always @* begin
        acc_d = acc_q + `UMFC_PRESC_STEP;
        tick_d = 1'b0;
        if (!enable) begin
            acc_d = 9'h000;
            tick_d = 1'b1;
        end else if (acc_d >= div_w) begin
            acc_d = acc_d - div_w;
            tick_d = 1'b1;
        end
    end

    // accumulator and tick flops
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 9'h000;
            tick_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

endmodule

// file: umfc_top.v
`timescale 1ns/1ns
`include "umfc_defines.vh"

module umfc_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata_q,
    input wire fifo_depth_strap_pin,
    input wire ri_n,
    input wire dsr_n,
    input wire modem_dtr_n,
    input wire local_tx_stop,
    input wire rx_push,
    input wire rx_pop,
    input wire tx_push,
    input wire tx_pop,
    output reg dtr_n_q,
    output reg [7:0] fifo_depth_q,
    output wire legacy_features_en,
    output wire enhanced_features_en,
    output wire tx_enable,
    output wire rx_enable,
    output reg [7:0] rx_trigger_level_q,
    output reg [7:0] tx_trigger_level_q,
    output reg remote_stop_q,
    output reg [4:0] tx_sample_count_q,
    output reg [4:0] rx_sample_count_q,
    output reg tx_clk_tick_q,
    output reg rx_clk_tick_q
);

    // ==========================================================
    // bus state machine
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WRITE = 4'b0010;
    localparam [3:0] ST_RWAIT = 4'b0100;
    localparam [3:0] ST_RDONE = 4'b1000;

    reg [3:0] st_q;
    reg [3:0] st_d;
    reg [7:0] addr_q;
    wire accept;
    wire wr_en;
    wire [7:0] wdat;

    assign hreadyout = ~st_q[2];
    assign hresp = 1'b0;
    assign accept = hsel & htrans[1] & hready;
    assign wr_en = st_q[1];
    assign wdat = hwdata[7:0];

    // next state: writes finish in their data phase, reads wait one cycle
    always @* begin
        case (st_q)
            ST_RWAIT: st_d = ST_RDONE;
            ST_IDLE, ST_WRITE, ST_RDONE: begin
                if (accept) begin
                    st_d = hwrite ? ST_WRITE : ST_RWAIT;
                end else begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // state and captured address
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_IDLE;
            addr_q <= 8'h00;
        end else begin
            st_q <= st_d;
            if (accept && !st_q[2]) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // ==========================================================
    // control registers
    reg fifo_en_q;
    reg fifo_size_q;
    reg [3:0] fcr_trig_q;
    reg [7:0] line_ctrl_q;
    reg [7:0] enh_feat_q;
    reg [7:0] add_ctrl_q;
    reg [7:0] mode_ctrl_q;
    reg [7:0] index_q;
    reg [7:0] clock_prescale_q;
    reg [7:0] external_clock_select_q;
    reg [7:0] oversample_q;
    reg [7:0] rx_trig_reg_q;
    reg [7:0] tx_trig_reg_q;
    reg [7:0] flow_lo_q;
    reg [7:0] flow_hi_q;
    reg [1:0] flush_q;
    wire enh;
    wire fcr_wr;
    wire size_next;

    assign fcr_wr = wr_en && (addr_q == `UMFC_A_FIFO_CTRL);
    assign enh = enh_feat_q[`UMFC_B_ENHANCED];
    // size bit only moves while latch access is open
    assign size_next = line_ctrl_q[`UMFC_B_DLAB] ? wdat[`UMFC_B_FIFO_SIZE] : fifo_size_q;

    // register writes and flush pulses
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_en_q <= 1'b0;
            fifo_size_q <= 1'b0;
            fcr_trig_q <= 4'h0;
            line_ctrl_q <= `UMFC_RST_ZERO;
            enh_feat_q <= `UMFC_RST_ZERO;
            add_ctrl_q <= `UMFC_RST_ZERO;
            mode_ctrl_q <= `UMFC_RST_ZERO;
            index_q <= `UMFC_RST_ZERO;
            clock_prescale_q <= `UMFC_RST_PRESCALE;
            external_clock_select_q <= `UMFC_RST_ZERO;
            oversample_q <= `UMFC_RST_OVERSAMPLE;
            rx_trig_reg_q <= `UMFC_RST_RX_TRIG;
            tx_trig_reg_q <= `UMFC_RST_ZERO;
            flow_lo_q <= `UMFC_RST_ZERO;
            flow_hi_q <= `UMFC_RST_FLOW_HI;
            flush_q <= 2'b00;
        end else begin
            flush_q <= 2'b00;
            if (wr_en) begin
                case (addr_q)
                    `UMFC_A_FIFO_CTRL: begin
                        fifo_en_q <= wdat[`UMFC_B_FIFO_EN];
                        fifo_size_q <= size_next;
                        fcr_trig_q <= wdat[7:4];
                        flush_q <= {wdat[`UMFC_B_TX_FLUSH], wdat[`UMFC_B_RX_FLUSH]};
                    end
                    `UMFC_A_LINE_CTRL: line_ctrl_q <= wdat;
                    `UMFC_A_ENH_FEAT: enh_feat_q <= wdat;
                    `UMFC_A_ADD_CTRL: add_ctrl_q <= wdat;
                    `UMFC_A_MODE_CTRL: mode_ctrl_q <= wdat;
                    `UMFC_A_INDEX: index_q <= wdat;
                    `UMFC_A_INDEX_DATA: begin
                        case (index_q)
                            `UMFC_IX_PRESCALE: clock_prescale_q <= wdat;
                            `UMFC_IX_EXT_CLK: external_clock_select_q <= wdat;
                            `UMFC_IX_OVERSAMPLE: oversample_q <= wdat;
                            `UMFC_IX_RX_TRIG: rx_trig_reg_q <= wdat;
                            `UMFC_IX_TX_TRIG: tx_trig_reg_q <= wdat;
                            `UMFC_IX_FLOW_LO: flow_lo_q <= wdat;
                            `UMFC_IX_FLOW_HI: flow_hi_q <= wdat;
                            default: index_q <= index_q;
                        endcase
                    end
                    default: index_q <= index_q;
                endcase
            end
        end
    end

    // ==========================================================
    // fifo depth selection
    reg strap_q;
    reg strap_taken_q;

    function [7:0] depth_of;
        input fe;
        input enhanced;
        input strap;
        input size;
        begin
            if (!fe) begin
                depth_of = `UMFC_DEPTH_BYTE;
            end else if (enhanced || strap) begin
                depth_of = `UMFC_DEPTH_LARGE;
            end else if (size) begin
                depth_of = `UMFC_DEPTH_LARGE;
            end else begin
                depth_of = `UMFC_DEPTH_SMALL;
            end
        end
    endfunction

    // strap caught once after reset release and then held static
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_q <= 1'b0;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_q <= fifo_depth_strap_pin;
            strap_taken_q <= 1'b1;
        end
    end

    // depth re-applied on each enable write or mode change
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_depth_q <= `UMFC_DEPTH_BYTE;
        end else if (fcr_wr) begin
            fifo_depth_q <= depth_of(wdat[`UMFC_B_FIFO_EN], enh, strap_q, size_next);
        end else if (wr_en && (addr_q == `UMFC_A_ENH_FEAT)) begin
            fifo_depth_q <= depth_of(fifo_en_q, wdat[`UMFC_B_ENHANCED], strap_q, fifo_size_q);
        end
    end

    // feature gating by mode
    assign legacy_features_en = fifo_en_q & ~enh;
    assign enhanced_features_en = enh;
    assign tx_enable = ~(enh & add_ctrl_q[`UMFC_B_TX_DISABLE]);
    assign rx_enable = ~(enh & add_ctrl_q[`UMFC_B_RX_DISABLE]);

    // ==========================================================
    // fill level counters
    wire [1:0] push_w;
    wire [1:0] pop_w;
    wire [15:0] fill_w;
    wire fe_change;

    assign push_w = {tx_push, rx_push};
    assign pop_w = {tx_pop, rx_pop};
    assign fe_change = fcr_wr && (wdat[`UMFC_B_FIFO_EN] != fifo_en_q);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_fill
            reg [7:0] cnt_q;
            assign fill_w[gi*8 +: 8] = cnt_q;
            // saturating count, clamped when the depth shrinks
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_q <= 8'h00;
                end else if (flush_q[gi] || fe_change) begin
                    cnt_q <= 8'h00;
                end else if (cnt_q > fifo_depth_q) begin
                    cnt_q <= fifo_depth_q;
                end else if (push_w[gi] && !pop_w[gi] && (cnt_q < fifo_depth_q)) begin
                    cnt_q <= cnt_q + 8'h01;
                end else if (pop_w[gi] && !push_w[gi] && (cnt_q != 8'h00)) begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
        end
    endgenerate

    // ==========================================================
    // trigger levels and flow thresholds
    reg [7:0] flow_hi_lvl_q;
    reg [7:0] flow_lo_lvl_q;
    reg [7:0] rx_legacy;
    reg [7:0] tx_legacy;
    wire arb_trig;

    assign arb_trig = enh & add_ctrl_q[`UMFC_B_ARB_TRIG];

    function [7:0] bound;
        input [7:0] lvl;
        input [7:0] dep;
        begin
            bound = (lvl > dep) ? dep : lvl;
        end
    endfunction

    // legacy tables from the upper trigger bits
    always @* begin
        rx_legacy = `UMFC_DEPTH_BYTE;
        tx_legacy = 8'h00;
        if (fifo_depth_q == `UMFC_DEPTH_SMALL) begin
            case (fcr_trig_q[3:2])
                2'h0: rx_legacy = 8'h01;
                2'h1: rx_legacy = 8'h04;
                2'h2: rx_legacy = 8'h08;
                default: rx_legacy = 8'h0E;
            endcase
        end else if (fifo_depth_q == `UMFC_DEPTH_LARGE) begin
            case (fcr_trig_q[3:2])
                2'h0: rx_legacy = 8'h10;
                2'h1: rx_legacy = 8'h20;
                2'h2: rx_legacy = 8'h70;
                default: rx_legacy = 8'h78;
            endcase
        end
        if (enh && (fifo_depth_q == `UMFC_DEPTH_LARGE)) begin
            case (fcr_trig_q[1:0])
                2'h0: tx_legacy = 8'h10;
                2'h1: tx_legacy = 8'h20;
                2'h2: tx_legacy = 8'h40;
                default: tx_legacy = 8'h70;
            endcase
        end
    end

    // level registers replace the upper trigger bits when selected
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_trigger_level_q <= `UMFC_DEPTH_BYTE;
            tx_trigger_level_q <= 8'h00;
            flow_hi_lvl_q <= `UMFC_DEPTH_BYTE;
            flow_lo_lvl_q <= 8'h00;
        end else if (arb_trig) begin
            rx_trigger_level_q <= bound(rx_trig_reg_q, fifo_depth_q);
            tx_trigger_level_q <= bound(tx_trig_reg_q, fifo_depth_q);
            flow_hi_lvl_q <= bound(flow_hi_q, fifo_depth_q);
            flow_lo_lvl_q <= bound(flow_lo_q, fifo_depth_q);
        end else begin
            rx_trigger_level_q <= bound(rx_legacy, fifo_depth_q);
            tx_trigger_level_q <= bound(tx_legacy, fifo_depth_q);
            flow_hi_lvl_q <= bound(rx_legacy, fifo_depth_q);
            flow_lo_lvl_q <= 8'h00;
        end
    end

    // remote transmitter told to stop at or above high, resumed at or below low
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remote_stop_q <= 1'b0;
        end else if (fill_w[7:0] >= flow_hi_lvl_q) begin
            remote_stop_q <= 1'b1;
        end else if (fill_w[7:0] <= flow_lo_lvl_q) begin
            remote_stop_q <= 1'b0;
        end
    end

    // ==========================================================
    // clocking: prescaler, external clocks, oversampling
    wire presc_tick;
    wire ck_tx_ext;
    wire ck_rx_ext;
    reg ri_prev_q;
    reg dsr_prev_q;

    umfc_prescaler u_presc (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(enh & mode_ctrl_q[`UMFC_B_PRESC_EN]),
        .divisor(clock_prescale_q),
        .tick_q(presc_tick)
    );

    assign ck_tx_ext = enh & external_clock_select_q[`UMFC_B_CK_TX_EXT];
    assign ck_rx_ext = enh & external_clock_select_q[`UMFC_B_CK_RX_EXT];

    function [4:0] osr_of;
        input [7:0] code;
        begin
            if (code[3:0] < `UMFC_OSR_MIN) begin
                osr_of = `UMFC_OSR_DEFAULT;
            end else begin
                osr_of = {1'b0, code[3:0]};
            end
        end
    endfunction

    // clock ticks from pin edges or the prescaler, dtr carries tx clock when enhanced and its select bit is set
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ri_prev_q <= 1'b1;
            dsr_prev_q <= 1'b1;
            tx_clk_tick_q <= 1'b0;
            rx_clk_tick_q <= 1'b0;
            dtr_n_q <= 1'b1;
            tx_sample_count_q <= `UMFC_OSR_DEFAULT;
            rx_sample_count_q <= `UMFC_OSR_DEFAULT;
        end else begin
            ri_prev_q <= ri_n;
            dsr_prev_q <= dsr_n;
            tx_clk_tick_q <= ck_tx_ext ? (ri_n & ~ri_prev_q) : presc_tick;
            rx_clk_tick_q <= ck_rx_ext ? (dsr_n & ~dsr_prev_q) : presc_tick;
            if (enh && external_clock_select_q[`UMFC_B_CK_DTR_OUT]) begin
                dtr_n_q <= ck_tx_ext ? ri_n : presc_tick;
            end else begin
                dtr_n_q <= modem_dtr_n;
            end
            if (ck_tx_ext && external_clock_select_q[`UMFC_B_CK_TX_1X]) begin
                tx_sample_count_q <= `UMFC_OSR_ONE;
            end else begin
                tx_sample_count_q <= enh ? osr_of(oversample_q) : `UMFC_OSR_DEFAULT;
            end
            if (ck_rx_ext && external_clock_select_q[`UMFC_B_CK_RX_1X]) begin
                rx_sample_count_q <= `UMFC_OSR_ONE;
            end else begin
                rx_sample_count_q <= enh ? osr_of(oversample_q) : `UMFC_OSR_DEFAULT;
            end
        end
    end

    // ==========================================================
    // read data, loaded in the wait cycle of a read
    reg [7:0] rd_val;

    always @* begin
        case (addr_q)
            `UMFC_A_FIFO_CTRL: rd_val = {fcr_trig_q, 2'b00, fifo_size_q, fifo_en_q};
            `UMFC_A_LINE_CTRL: rd_val = line_ctrl_q;
            `UMFC_A_ENH_FEAT: rd_val = enh_feat_q;
            `UMFC_A_ADD_CTRL: rd_val = add_ctrl_q;
            `UMFC_A_MODE_CTRL: rd_val = mode_ctrl_q;
            `UMFC_A_INDEX: rd_val = index_q;
            `UMFC_A_INDEX_DATA: begin
                case (index_q)
                    `UMFC_IX_PRESCALE: rd_val = clock_prescale_q;
                    `UMFC_IX_EXT_CLK: rd_val = external_clock_select_q;
                    `UMFC_IX_OVERSAMPLE: rd_val = oversample_q;
                    `UMFC_IX_RX_TRIG: rd_val = rx_trig_reg_q;
                    `UMFC_IX_TX_TRIG: rd_val = tx_trig_reg_q;
                    `UMFC_IX_FLOW_LO: rd_val = flow_lo_q;
                    `UMFC_IX_FLOW_HI: rd_val = flow_hi_q;
                    default: rd_val = 8'h00;
                endcase
            end
            `UMFC_A_ADD_STATUS: rd_val = {6'h00, remote_stop_q, local_tx_stop};
            `UMFC_A_RX_FILL: rd_val = fill_w[7:0];
            `UMFC_A_TX_FILL: rd_val = fill_w[15:8];
            `UMFC_A_MODE_STATUS: rd_val = fifo_depth_q;
            default: rd_val = 8'h00;
        endcase
    end

    // hrdata register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (st_q[2]) begin
            hrdata_q <= {24'h000000, rd_val};
        end
    end

endmodule

// file: umfc_top_asserts.sv
`timescale 1ns/1ns
// ==========================================================
// port checks on the mode and clock block
module umfc_top_asserts (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire [7:0] fifo_depth_q,
    input wire legacy_features_en,
    input wire enhanced_features_en,
    input wire tx_enable,
    input wire rx_enable,
    input wire [7:0] rx_trigger_level_q,
    input wire [4:0] tx_sample_count_q,
    input wire [4:0] rx_sample_count_q
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // requests accepted by the slave
    wire take = hsel && htrans[1] && hready;
    wire rd_take = take && !hwrite;
    wire wr_take = take && hwrite;
    property p_depth;
        fifo_depth_q == 8'h01 || fifo_depth_q == 8'h10 || fifo_depth_q == 8'h80;
    endproperty
    property p_legacy;
        legacy_features_en |-> !enhanced_features_en;
    endproperty
    property p_osr;
        (tx_sample_count_q == 5'h01 || (tx_sample_count_q >= 5'h04 && tx_sample_count_q <= 5'h10))
        && (rx_sample_count_q == 5'h01 || (rx_sample_count_q >= 5'h04 && rx_sample_count_q <= 5'h10));
    endproperty
    property p_trig;
        $stable(fifo_depth_q) |-> rx_trigger_level_q <= fifo_depth_q;
    endproperty
    property p_wait;
        !hreadyout |-> $past(rd_take);
    endproperty
    property p_read;
        rd_take |=> !hreadyout ##1 hreadyout;
    endproperty
    property p_gate;
        !(tx_enable && rx_enable) |-> enhanced_features_en;
    endproperty
    property p_dep_cause;
        $changed(fifo_depth_q) |-> $past(wr_take, 2) || $past(wr_take, 3);
    endproperty
    a_depth: assert property (p_depth) else $error("bad depth");
    a_legacy: assert property (p_legacy) else $error("legacy in enhanced");
    a_osr: assert property (p_osr) else $error("bad sample count");
    a_trig: assert property (p_trig) else $error("trigger above depth");
    a_wait: assert property (p_wait) else $error("stray wait");
    a_read: assert property (p_read) else $error("read answer late");
    a_gate: assert property (p_gate) else $error("disable outside enhanced");
    a_dep_cause: assert property (p_dep_cause) else $error("depth moved alone");
    c_read: cover property (rd_take);
    c_deep: cover property (fifo_depth_q == 8'h80);
    c_txoff: cover property (!tx_enable);
endmodule

bind umfc_top umfc_top_asserts u_chk (.*);

// file: umfc_line_model.sv
`timescale 1ns/1ns
// ==========================================================
// far side: external clocks on ring and dsr lines
module umfc_line_model (
    input wire hclk,
    input wire run,
    output logic ri_n,
    output logic dsr_n
);
    logic [3:0] cnt_q = 4'h0;
    initial ri_n = 1'b1;
    initial dsr_n = 1'b1;
    // clocks only run in frames, idle high like unused pins
    always @(posedge hclk) begin
        cnt_q <= run ? cnt_q + 4'h1 : 4'h0;
        ri_n <= run ? cnt_q[2] : 1'b1;
        dsr_n <= run ? cnt_q[3] : 1'b1;
    end
endmodule

// file: uart_mode_fifo_clock_config_test.sv
`timescale 1ns/1ns
// ==========================================================
// bench for the mode and clock block
module uart_mode_fifo_clock_config_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fifo_depth_strap_pin = 0, run = 0;
    logic modem_dtr_n = 1, local_tx_stop = 0, rx_push = 0, rx_pop = 0, tx_push = 0, tx_pop = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    wire hready, hreadyout, hresp, ri_n, dsr_n, dtr_n_q, legacy_features_en, enhanced_features_en;
    wire tx_enable, rx_enable, remote_stop_q, tx_clk_tick_q, rx_clk_tick_q;
    wire [31:0] hrdata_q;
    wire [7:0] fifo_depth_q, rx_trigger_level_q, tx_trigger_level_q;
    wire [4:0] tx_sample_count_q, rx_sample_count_q;
    int err_count = 0, num_checks = 0, ntx, nrx, nri, ndtr, rc, tc;
    logic [15:0] lf = 16'h5CB6;
    logic [7:0] v;
    logic ri_d, dtr_d;
    assign hready = hreadyout;
    umfc_top dut (.*);
    umfc_line_model u_line (.hclk(hclk), .run(run), .ri_n(ri_n), .dsr_n(dsr_n));
    always #25 hclk = ~hclk;
    // edge counters for the clock window
    always @(posedge hclk) begin
        ntx += tx_clk_tick_q;
        nrx += rx_clk_tick_q;
        nri += (ri_n && !ri_d);
        ndtr += (dtr_n_q && !dtr_d);
        ri_d = ri_n;
        dtr_d = dtr_n_q;
    end
    function logic [15:0] nx(input logic [15:0] s);
        nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function logic [4:0] osr(input logic [7:0] x);
        osr = (x[3:0] < 4'h4) ? 5'h10 : {1'b0, x[3:0]};
    endfunction
    function int sat(input int c, input logic p, input logic q, input int d);
        sat = (p && !q && c < d) ? c + 1 : (q && !p && c > 0) ? c - 1 : c;
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // one bus transfer, address phase then data phase
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata_q;
    endtask
    task ix(input logic w, input logic [7:0] i, input logic [7:0] d);
        xfer(1, 8'h14, i);
        xfer(w, 8'h18, d);
    endtask
    task dep(input logic [7:0] e);
        xfer(0, 8'h28, 0);
        chk(rd, {24'h0, e});
        chk(fifo_depth_q, e);
    endtask
    task rst(input logic s);
        hresetn <= 0;
        fifo_depth_strap_pin <= s;
        repeat (12) @(posedge hclk);
        hresetn <= 1;
    endtask
    task results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        results;
    end
    initial begin
        rst(0);
        xfer(0, 8'h00, 0);
        chk(rd, 0);
        chk(hresp, 0);
        dep(8'h01);
        ix(0, 8'h01, 0);
        chk(rd, 32'h20);
        ix(0, 8'h03, 0);
        chk(rd, 0);
        xfer(0, 8'h3C, 0);
        chk(rd, 0);
        $display("reset values done");
        xfer(1, 8'h00, 8'h21);
        dep(8'h10);
        xfer(0, 8'h00, 0);
        chk(rd, 32'h21);
        rc = 0;
        tc = 0;
        repeat (60) begin
            @(posedge hclk);
            lf = nx(lf);
            {rx_push, rx_pop, tx_push, tx_pop, local_tx_stop} <= {lf[0], lf[5] & lf[7], lf[3], lf[9] & lf[2], lf[4]};
            rc = sat(rc, lf[0], lf[5] & lf[7], 16);
            tc = sat(tc, lf[3], lf[9] & lf[2], 16);
        end
        @(posedge hclk);
        {rx_push, rx_pop, tx_push, tx_pop} <= 0;
        xfer(0, 8'h20, 0);
        chk(rd, rc);
        xfer(0, 8'h24, 0);
        chk(rd, tc);
        xfer(0, 8'h1C, 0);
        chk(rd[0], lf[4]);
        chk(rd[1], rc != 0);
        $display("fill levels done");
        xfer(1, 8'h04, 8'h80);
        xfer(1, 8'h00, 8'h21);
        dep(8'h80);
        xfer(1, 8'h00, 8'h00);
        xfer(1, 8'h04, 8'h00);
        xfer(1, 8'h08, 8'h10);
        dep(8'h01);
        xfer(1, 8'h00, 8'h01);
        dep(8'h80);
        chk(legacy_features_en, 0);
        $display("depth modes done");
        for (int i = 0; i < 10; i++) begin
            lf = nx(lf);
            v = (i == 0) ? 8'h03 : (i == 1) ? 8'h04 : lf[7:0];
            ix(1, 8'h03, v);
            repeat (2) @(posedge hclk);
            chk(tx_sample_count_q, osr(v));
            chk(rx_sample_count_q, osr(v));
        end
        xfer(1, 8'h0C, 8'h03);
        @(posedge hclk);
        chk(tx_enable, 0);
        chk(rx_enable, 0);
        ix(1, 8'h04, 8'h25);
        ix(1, 8'h05, 8'h90);
        xfer(1, 8'h0C, 8'h20);
        repeat (2) @(posedge hclk);
        chk(rx_trigger_level_q, 8'h25);
        chk(tx_trigger_level_q, 8'h80);
        xfer(1, 8'h0C, 8'h00);
        repeat (2) @(posedge hclk);
        chk(rx_trigger_level_q, 8'h10);
        chk(tx_trigger_level_q, 8'h10);
        $display("sampling done");
        ix(1, 8'h01, 8'h14);
        ix(1, 8'h02, 8'h90);
        xfer(1, 8'h10, 8'h01);
        repeat (4) @(posedge hclk);
        {ntx, nrx, nri, ndtr} = 0;
        run <= 1;
        repeat (160) @(posedge hclk);
        run <= 0;
        chk(nrx >= 63 && nrx <= 65, 1);
        repeat (4) @(posedge hclk);
        chk(ntx >= nri - 1 && ntx <= nri + 1 && nri > 10, 1);
        chk(ndtr > 10, 1);
        ix(1, 8'h02, 8'hB3);
        repeat (2) @(posedge hclk);
        chk(tx_sample_count_q, 1);
        chk(rx_sample_count_q, 1);
        {ntx, nrx, nri, ndtr} = 0;
        run <= 1;
        repeat (160) @(posedge hclk);
        run <= 0;
        repeat (4) @(posedge hclk);
        chk(nrx >= 9 && nrx <= 11, 1);
        $display("clocks done");
        rst(1);
        xfer(1, 8'h00, 8'h01);
        dep(8'h80);
        $display("strap done");
        results;
    end
endmodule
